/* File: src/dpg_regs.svh */
`ifndef DPG_REGS_SVH
`define DPG_REGS_SVH

// register indexes; byte address is four times the index
`define DPG_IDX_PIN_FUNC    8'h9b
`define DPG_IDX_DUTY1       8'hb4
`define DPG_IDX_CTRL0       8'hd3
`define DPG_IDX_CTRL1       8'hd4
`define DPG_IDX_DUTY0       8'hb3
`define DPG_IDX_CNT0        8'hd5
`define DPG_IDX_CNT1        8'hd6
`define DPG_IDX_STATUS      8'hd7

// field positions
`define DPG_BIT_SDA_REL     7
`define DPG_BIT_SCL_REL     6
`define DPG_BIT_MOD1_ON     3
`define DPG_BIT_MOD0_ON     2
`define DPG_BIT_SHORT_RES   2
`define DPG_BIT_DIV_HI      1
`define DPG_BIT_DIV_LO      0

// writable bits and reset values
`define DPG_MASK_PIN_FUNC   8'hcc
`define DPG_MASK_CTRL       8'h07
`define DPG_RST_PIN_FUNC    8'h00
`define DPG_RST_CTRL        8'h00
`define DPG_RST_DUTY        8'h00

// counter limits
`define DPG_MAX_LONG        8'hff
`define DPG_MAX_SHORT       8'h1f

// prescaler terminal counts for divide by 4, 8, 16, 32
`define DPG_TC_DIV4         5'h03
`define DPG_TC_DIV8         5'h07
`define DPG_TC_DIV16        5'h0f
`define DPG_TC_DIV32        5'h1f

`endif

/* File: src/dpg_pkg.sv */
package dpg_pkg;

  // data phase of the bus slave
  typedef enum logic [2:0] {
    DPG_PH_IDLE  = 3'b001,
    DPG_PH_WRITE = 3'b010,
    DPG_PH_READ  = 3'b100
  } dpg_phase_t;

  // modulator control register layout
  typedef struct packed {
    logic [4:0] unused;
    logic       short_resolution_select;
    logic       divider_select_hi;
    logic       divider_select_lo;
  } dpg_ctrl_t;

  // settings handed to one channel
  typedef struct packed {
    logic       enable;
    logic       duty_valid;
    dpg_ctrl_t  ctrl;
    logic [7:0] duty_value;
  } dpg_chan_cfg_t;

endpackage

/* File: src/dpg_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpg_regs.svh"

module dpg_prescaler (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic [1:0] div_sel,
  output logic            tick
);
  import dpg_pkg::*;

  logic [4:0] div_cnt_q;
  logic [4:0] div_cnt_d;
  logic [4:0] term_cnt;

  // terminal count from divider select
  always_comb begin
    unique case (div_sel)
      2'b00: term_cnt = `DPG_TC_DIV4;
      2'b01: term_cnt = `DPG_TC_DIV8;
      2'b10: term_cnt = `DPG_TC_DIV16;
      2'b11: term_cnt = `DPG_TC_DIV32;
    endcase
  end

  // one tick per divider period; held in reset while stopped
  always_comb begin
    tick      = run && (div_cnt_q >= term_cnt);
    div_cnt_d = div_cnt_q + 5'h01;
    if (!run || tick) begin
      div_cnt_d = 5'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

endmodule // dpg_prescaler
`default_nettype wire

/* File: src/dpg_channel.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpg_regs.svh"

module dpg_channel (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   tick,
  input  wire dpg_pkg::dpg_chan_cfg_t cfg,
  output logic [7:0]                  count,
  output logic                        wave
);
  import dpg_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       hit_q;
  logic       hit_d;
  logic       wave_q;
  logic       wave_d;
  logic [7:0] cnt_max;
  logic [7:0] cmp_val;
  logic       wrap;

  // counter, match latch and comparator
  always_comb begin
    cnt_max = cfg.ctrl.short_resolution_select ? `DPG_MAX_SHORT : `DPG_MAX_LONG;
    cmp_val = cfg.ctrl.short_resolution_select ? {3'h0, cfg.duty_value[4:0]} : cfg.duty_value;
    wrap    = tick && (cnt_q >= cnt_max);
    cnt_d   = cnt_q;
    if (!cfg.enable || wrap) begin
      cnt_d = 8'h00;
    end else if (tick) begin
      cnt_d = cnt_q + 8'h01;
    end
    // once equal, low until the next overflow
    // a match only counts once a duty value exists, so a late duty write takes hold at once
    hit_d = cfg.enable && cfg.duty_valid && !wrap && (hit_q || (cnt_q == cmp_val));
    // duty compared live, no shadow copy
    wave_d = cfg.enable && cfg.duty_valid && !hit_d
             && (cnt_d < cmp_val);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= 8'h00;
      hit_q  <= 1'b0;
      wave_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      hit_q  <= hit_d;
      wave_q <= wave_d;
    end
  end

  assign count = cnt_q;
  assign wave  = wave_q;

endmodule // dpg_channel
`default_nettype wire

/* File: src/dpg_top.sv */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dpg_regs.svh"

module dpg_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [2:0]  hburst,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        port1_pin2_latch,
  input  wire logic        port1_pin3_latch,
  output logic             port1_pin2_out,
  output logic             port1_pin3_out,
  output logic             serial_data_pin_release,
  output logic             serial_clock_pin_release
);
  import dpg_pkg::*;

  // bus phase tracking
  dpg_phase_t phase_q;
  dpg_phase_t phase_d;
  logic [7:0] widx_q;
  logic [7:0] widx_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic       addr_ok;
  logic       take;
  logic [7:0] aidx;

  // software registers
  logic [7:0] pin_func_q;
  logic [7:0] pin_func_d;
  dpg_ctrl_t  ctrl0_q;
  dpg_ctrl_t  ctrl0_d;
  dpg_ctrl_t  ctrl1_q;
  dpg_ctrl_t  ctrl1_d;
  logic [7:0] duty0_q;
  logic [7:0] duty0_d;
  logic [7:0] duty1_q;
  logic [7:0] duty1_d;
  logic [1:0] duty_seen_q;
  logic [1:0] duty_seen_d;
  logic [7:0] wbyte;
  logic       wr_pin_func;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_duty;

  // channel side
  dpg_chan_cfg_t cfg [2];
  logic [1:0]    tick;
  logic [1:0]    wave;
  logic [7:0]    count [2];
  logic [1:0]    chan_on;
  logic [1:0]    latch;

  // pin drivers
  logic [1:0] pin_q;
  logic [1:0] pin_d;

  // burst and protection carry no meaning for single word registers
  logic unused_ok;
  assign unused_ok = &{1'b0, hburst, hprot, hsize, hwdata[31:8]};

  // address phase decode, zero wait state slave
  always_comb begin
    aidx    = haddr[9:2];
    addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
    take    = hsel && hready && htrans[1];
  end

  // next bus phase
  always_comb begin
    phase_d = DPG_PH_IDLE;
    widx_d  = widx_q;
    if (take) begin
      widx_d = addr_ok ? aidx : 8'h00;
      if (hwrite) begin
        phase_d = DPG_PH_WRITE;
      end else begin
        phase_d = DPG_PH_READ;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= DPG_PH_IDLE;
      widx_q  <= 8'h00;
    end else begin
      phase_q <= phase_d;
      widx_q  <= widx_d;
    end
  end

  // write strobes, live only in the data phase of a write; unmapped writes dropped
  always_comb begin
    wbyte       = hwdata[7:0];
    wr_pin_func = 1'b0;
    wr_ctrl     = 2'b00;
    wr_duty     = 2'b00;
    if (phase_q == DPG_PH_WRITE) begin
      unique case (widx_q)
        `DPG_IDX_PIN_FUNC: begin
          wr_pin_func = 1'b1;
        end
        `DPG_IDX_CTRL0: begin
          wr_ctrl[0] = 1'b1;
        end
        `DPG_IDX_CTRL1: begin
          wr_ctrl[1] = 1'b1;
        end
        `DPG_IDX_DUTY0: begin
          wr_duty[0] = 1'b1;
        end
        `DPG_IDX_DUTY1: begin
          wr_duty[1] = 1'b1;
        end
        default: begin
          wr_pin_func = 1'b0;  // no register behind this index
        end
      endcase
    end
  end

  // enable and release register; reserved bits stay zero
  always_comb begin
    pin_func_d = pin_func_q;
    if (wr_pin_func) begin
      pin_func_d = wbyte & `DPG_MASK_PIN_FUNC;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_func_q <= `DPG_RST_PIN_FUNC;
    end else begin
      pin_func_q <= pin_func_d;
    end
  end

  // control registers; bits 7:3 read back as zero
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    if (wr_ctrl[0]) begin
      ctrl0_d = dpg_ctrl_t'(wbyte & `DPG_MASK_CTRL);
    end
    if (wr_ctrl[1]) begin
      ctrl1_d = dpg_ctrl_t'(wbyte & `DPG_MASK_CTRL);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_q <= dpg_ctrl_t'(`DPG_RST_CTRL);
      ctrl1_q <= dpg_ctrl_t'(`DPG_RST_CTRL);
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
    end
  end

  // duty registers, and a flag per channel that a duty value has been written
  always_comb begin
    duty0_d     = duty0_q;
    duty1_d     = duty1_q;
    duty_seen_d = duty_seen_q | wr_duty;
    if (wr_duty[0]) begin
      duty0_d = wbyte;
    end
    if (wr_duty[1]) begin
      duty1_d = wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      duty0_q     <= `DPG_RST_DUTY;
      duty1_q     <= `DPG_RST_DUTY;
      duty_seen_q <= 2'b00;
    end else begin
      duty0_q     <= duty0_d;
      duty1_q     <= duty1_d;
      duty_seen_q <= duty_seen_d;
    end
  end

  // read data of writable registers taken from next values so a read right after a write sees it
  always_comb begin
    rdata_d = 32'h00000000;
    if (take && !hwrite && addr_ok) begin
      unique case (aidx)
        `DPG_IDX_PIN_FUNC: rdata_d = {24'h000000, pin_func_d};
        `DPG_IDX_CTRL0:    rdata_d = {24'h000000, ctrl0_d};
        `DPG_IDX_CTRL1:    rdata_d = {24'h000000, ctrl1_d};
        `DPG_IDX_DUTY0:    rdata_d = {24'h000000, duty0_d};
        `DPG_IDX_DUTY1:    rdata_d = {24'h000000, duty1_d};
        `DPG_IDX_CNT0:     rdata_d = {24'h000000, count[0]};
        `DPG_IDX_CNT1:     rdata_d = {24'h000000, count[1]};
        `DPG_IDX_STATUS:   rdata_d = {28'h0000000, duty_seen_q, wave};
        default:           rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // channel settings from the registers
  always_comb begin
    chan_on[0]        = pin_func_q[`DPG_BIT_MOD0_ON];
    chan_on[1]        = pin_func_q[`DPG_BIT_MOD1_ON];
    cfg[0].enable     = chan_on[0];
    cfg[0].duty_valid = duty_seen_q[0];
    cfg[0].ctrl       = ctrl0_q;
    cfg[0].duty_value = duty0_q;
    cfg[1].enable     = chan_on[1];
    cfg[1].duty_valid = duty_seen_q[1];
    cfg[1].ctrl       = ctrl1_q;
    cfg[1].duty_value = duty1_q;
    latch             = {port1_pin3_latch, port1_pin2_latch};
  end

  // two independent modulators, nothing shared but the clock and reset
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      dpg_prescaler u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (cfg[ch].enable),
        .div_sel ({cfg[ch].ctrl.divider_select_hi, cfg[ch].ctrl.divider_select_lo}),
        .tick    (tick[ch])
      );

      dpg_channel u_chan (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick[ch]),
        .cfg     (cfg[ch]),
        .count   (count[ch]),
        .wave    (wave[ch])
      );

      // pin follows latch when off; latch low lets the wave through
      always_comb begin
        if (chan_on[ch]) begin
          pin_d[ch] = latch[ch] | wave[ch];
        end else begin
          pin_d[ch] = latch[ch];
        end
      end
    end
  endgenerate

  // registered pin drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 2'b00;
    end else begin
      pin_q <= pin_d;
    end
  end

  // modulator pins and serial pin release; no interrupt output exists
  assign port1_pin2_out           = pin_q[0];
  assign port1_pin3_out           = pin_q[1];
  assign serial_data_pin_release  = pin_func_q[`DPG_BIT_SDA_REL];
  assign serial_clock_pin_release = pin_func_q[`DPG_BIT_SCL_REL];

endmodule // dpg_top
`default_nettype wire

/* File: testbench/dpg_load_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dpg_load_model (
  input  wire logic clk,
  input  wire logic pin,
  output int        period,
  output int        high_len,
  output int        rises
);
  int   run_q;
  int   hi_q;
  logic last_q = 1'b0;
  // time the pin between rising edges, and the width of each high part
  always @(posedge clk) begin
    last_q <= pin;
    run_q  <= run_q + 1;
    hi_q   <= pin ? hi_q + 1 : 0;
    if (pin && !last_q) begin
      period <= run_q;
      run_q  <= 1;
      rises  <= rises + 1;
    end
    if (!pin && last_q) high_len <= hi_q;
  end
endmodule // dpg_load_model
`default_nettype wire

/* File: testbench/dpg_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpg_regs.svh"
module dpg_top_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        port1_pin2_latch,
  input wire logic        port1_pin3_latch,
  input wire logic        port1_pin2_out,
  input wire logic        port1_pin3_out,
  input wire logic        serial_data_pin_release,
  input wire logic        serial_clock_pin_release
);
  logic       take;
  logic       wr_pf_q;
  logic       rd_q;
  logic       rd_pf_q;
  logic       rd_lo_q;
  logic [1:0] en_q;
  // follow bus transfers to know what the enable register holds
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pf_q <= 1'b0;
      rd_q    <= 1'b0;
      rd_pf_q <= 1'b0;
      rd_lo_q <= 1'b0;
      en_q    <= 2'h0;
    end else begin
      wr_pf_q <= take && hwrite && haddr == {22'h0, `DPG_IDX_PIN_FUNC, 2'h0};
      rd_q    <= take && !hwrite;
      rd_pf_q <= take && !hwrite && haddr == {22'h0, `DPG_IDX_PIN_FUNC, 2'h0};
      rd_lo_q <= take && !hwrite && haddr[9:2] < `DPG_IDX_PIN_FUNC;
      if (wr_pf_q && hready) en_q <= hwdata[3:2];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  pin2_gate_a: assert property ($past(hresetn) && $past(port1_pin2_latch) |-> port1_pin2_out)
    else $error("pin2 low with latch high");
  pin3_gate_a: assert property ($past(hresetn) && $past(port1_pin3_latch) |-> port1_pin3_out)
    else $error("pin3 low with latch high");
  pin_follow_a: assert property ($past(hresetn) && !en_q[0] && !$past(en_q[0])
    |-> port1_pin2_out == $past(port1_pin2_latch)) else $error("disabled pin2 not following latch");
  release_load_a: assert property (wr_pf_q |=>
    {serial_data_pin_release, serial_clock_pin_release} == $past(hwdata[7:6])) else $error("release bits not loaded");
  release_hold_a: assert property (!wr_pf_q |=>
    $stable({serial_data_pin_release, serial_clock_pin_release})) else $error("release bits changed without write");
  unmapped_zero_a: assert property (rd_lo_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  enable_read_a: assert property (rd_pf_q |-> hrdata[7:0] ==
    {serial_data_pin_release, serial_clock_pin_release, 2'h0, en_q, 2'h0}) else $error("enable register read wrong");
endmodule // dpg_top_asserts
bind dpg_top dpg_top_asserts u_dpg_top_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .port1_pin2_latch, .port1_pin3_latch, .port1_pin2_out,
  .port1_pin3_out, .serial_data_pin_release, .serial_clock_pin_release);
`default_nettype wire

/* File: testbench/dual_pwm_generator_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpg_regs.svh"
module dual_pwm_generator_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  latch = 2'h0;
  logic        ch = 1'b0;
  logic        hreadyout, hresp, out2, out3, sda_rel, scl_rel;
  logic [31:0] hrdata, rd;
  int          bad_count, total_checks, period, high_len, rises, e0;
  logic [7:0]  regs [5] = '{`DPG_IDX_DUTY0, `DPG_IDX_DUTY1, `DPG_IDX_CTRL0, `DPG_IDX_CTRL1, `DPG_IDX_PIN_FUNC};
  logic [7:0]  msk [5] = '{8'hff, 8'hff, 8'h07, 8'h07, 8'hcc};
  logic [7:0]  ct_t [4] = '{8'h00, 8'h05, 8'h02, 8'h07};
  logic [7:0]  du_t [4] = '{8'h40, 8'h2a, 8'hff, 8'h1f};
  int          per_t [4] = '{1024, 256, 4096, 1024};
  int          hi_t [4] = '{256, 80, 4080, 992};

  always #5 hclk = ~hclk;

  dpg_top u_dpg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hburst(3'h0), .hprot(4'h3), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port1_pin2_latch(latch[0]),
    .port1_pin3_latch(latch[1]), .port1_pin2_out(out2), .port1_pin3_out(out3),
    .serial_data_pin_release(sda_rel), .serial_clock_pin_release(scl_rel));

  dpg_load_model u_dpg_load_model (.clk(hclk), .pin(ch ? out3 : out2), .period(period),
    .high_len(high_len), .rises(rises));

  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single bus transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge hclk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) begin
      xfer(1'b0, regs[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    xfer(1'b0, 8'h00, 32'h0);
    chk("unmapped read", rd, 32'h0);
    // enable before any duty write, then change duty while running
    latch <= 2'h0;
    xfer(1'b1, `DPG_IDX_PIN_FUNC, 32'h04);
    repeat (300) @(posedge hclk);
    chk("pin before duty", {31'h0, out2}, 32'h0);
    xfer(1'b1, `DPG_IDX_DUTY0, 32'hff);
    repeat (4) @(posedge hclk);
    chk("pin after duty", {31'h0, out2}, 32'h1);
    xfer(1'b1, `DPG_IDX_DUTY0, 32'h01);
    repeat (4) @(posedge hclk);
    chk("pin after lower duty", {31'h0, out2}, 32'h0);
    // writable bits of every register
    foreach (regs[i]) begin
      xfer(1'b1, regs[i], 32'hffff_ffff);
      xfer(1'b0, regs[i], 32'h0);
      chk("write mask", rd, {24'h0, msk[i]});
    end
    chk("release both", {30'h0, sda_rel, scl_rel}, 32'h3);
    xfer(1'b1, `DPG_IDX_PIN_FUNC, 32'h40);
    @(posedge hclk);
    chk("release order", {30'h0, sda_rel, scl_rel}, 32'h1);
    xfer(1'b1, `DPG_IDX_PIN_FUNC, 32'h00);
    latch <= 2'h1;
    repeat (3) @(posedge hclk);
    chk("disabled pins", {30'h0, out3, out2}, 32'h1);
    latch <= 2'h0;
    // each divider code, both resolutions, both channels
    for (int k = 0; k < 4; k++) begin
      ch = k[0];
      xfer(1'b1, ch ? `DPG_IDX_DUTY1 : `DPG_IDX_DUTY0, {24'h0, du_t[k]});
      xfer(1'b1, ch ? `DPG_IDX_CTRL1 : `DPG_IDX_CTRL0, {24'h0, ct_t[k]});
      xfer(1'b1, `DPG_IDX_PIN_FUNC, ch ? 32'h08 : 32'h04);
      e0 = rises;
      for (int i = 0; i < 20000 && rises < e0 + 3; i++) @(posedge hclk);
      chk("period", 32'(period), 32'(per_t[k]));
      chk("high time", 32'(high_len), 32'(hi_t[k]));
      xfer(1'b1, `DPG_IDX_PIN_FUNC, 32'h00);
    end
    summarize();
  end
endmodule // dual_pwm_generator_test
`default_nettype wire
